// [pkg/oc_chan_pkg.sv]
// constants for the output compare and pwm channel
package oc_chan_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_PRIMARY = 8'h08;
    localparam logic [7:0] ADDR_SECONDARY = 8'h0c;
    localparam logic [7:0] ADDR_TIMER = 8'h10;
    // control one fields
    localparam int MODE_LSB = 0;
    localparam int TRIG_CLEAR_BIT = 3;
    localparam int FAULT_FLAG_BIT = 4;
    localparam int FAULT_EN_BIT = 7;
    // control two fields
    localparam int FAULT_HOLD_BIT = 15;
    localparam int FAULT_LEVEL_BIT = 14;
    localparam int FAULT_DIR_BIT = 13;
    localparam int INVERT_BIT = 12;
    localparam int DELAY_LSB = 9;
    localparam int CASCADE_BIT = 8;
    localparam int TRIG_SEL_BIT = 7;
    localparam int TRIG_STAT_BIT = 6;
    localparam int TRIS_BIT = 5;
    localparam int SRC_LSB = 0;
    // reset values and writable masks
    localparam logic [15:0] CTRL_TWO_RESET = 16'h000c;
    localparam logic [15:0] CTRL_TWO_MASK = 16'hf7ff;
    localparam logic [7:0] CTRL_ONE_MASK = 8'h8f;
    // compare modes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SET_HIGH = 3'h1;
    localparam logic [2:0] MODE_SET_LOW = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_ONE_PULSE = 3'h4;
    localparam logic [2:0] MODE_PULSES = 3'h5;
    localparam logic [2:0] MODE_EDGE_PWM = 3'h6;
    localparam logic [2:0] MODE_CENTER_PWM = 3'h7;
    // source selection codes
    localparam logic [4:0] SRC_NONE = 5'h00;
    localparam logic [4:0] SRC_SELF = 5'h1f;
    // timing: instruction cycle split into quarters of the system clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int INSTR_CYCLE_NS = 32;
    localparam int PHASES = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // single-shot sequencing
    typedef enum logic [1:0] {SHOT_ARMED, SHOT_HIGH, SHOT_DONE} shot_t;
endpackage

// [hw/output_compare_pwm_channel.sv]
// output compare channel with pwm, fault, trigger and axi4-lite registers
`timescale 1ns/10ps
//
// Function
// - modes 111 and 110 run center, edge pwm
// - mode 101 starts low, toggles on alternating matches
// - mode 100 starts low, gives one pulse
// - mode 011 toggles output on every primary match
// - mode 010 starts high, match drives low
// - mode 001 starts low, match drives high
// - mode 000 disables all compare activity
// - fault hold select chooses fault exit condition
// - fault drives output to fault level
// - fault direction bit forces pin to output
// - inversion bit inverts the output
// - sub-cycle field delays falling edge by quarters
// - delay moves to rising edge when inverted
// - cascade bit joins channels into 32 bits
// - trigger select picks trigger or synchronize
// - trigger status shows timer running or held
// - tristate bit releases the output pin
// - source field selects timer, channel or self
// - trigger clear mode allows hardware status clear
// - sub-cycle field double buffered in pwm
// - compare values latched at period end in pwm
module output_compare_pwm_channel
    import oc_chan_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // one pulse per selectable source, indexed by source code
    input wire logic [31:0] source_pulse,
    // fault input, high while a fault is present
    input wire logic fault_in,
    // the pin, output enable low while driving
    output logic compare_output_pin,
    output logic compare_output_oe_n
);
    import oc_chan_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0] ctrl_one_q; // mode, trigger clear, fault flag, enable
    logic [15:0] ctrl_two_q; // compare_channel_control_two
    logic [31:0] primary_q; // primary_compare_value
    logic [31:0] secondary_q; // secondary_compare_value
    logic [31:0] pri_act_q; // compare values in use
    logic [31:0] sec_act_q;
    logic [1:0] dcb_act_q; // sub-cycle delay in use
    logic [31:0] tmr_q; // channel_timer_count
    logic [1:0] phase_q; // quarter of instruction cycle
    logic [2:0] mode_prev_q; // mode seen last cycle
    logic raw_q; // compare level before delay
    logic pin_raw_q; // level after falling edge delay
    logic fault_act_q; // channel is in fault
    shot_t shot_q; // single-shot progress
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    ////////////////////////////////////////////////////////////////////
    // decoded fields
    wire [2:0] mode_w = ctrl_one_q[MODE_LSB +: 3];
    wire trig_clear_w = ctrl_one_q[TRIG_CLEAR_BIT];
    wire fault_flag_w = ctrl_one_q[FAULT_FLAG_BIT];
    wire fault_en_w = ctrl_one_q[FAULT_EN_BIT];
    wire fault_hold_w = ctrl_two_q[FAULT_HOLD_BIT];
    wire fault_lvl_w = ctrl_two_q[FAULT_LEVEL_BIT];
    wire fault_dir_w = ctrl_two_q[FAULT_DIR_BIT];
    wire invert_w = ctrl_two_q[INVERT_BIT];
    wire [1:0] dcb_w = ctrl_two_q[DELAY_LSB +: 2];
    wire cascade_w = ctrl_two_q[CASCADE_BIT];
    wire trig_sel_w = ctrl_two_q[TRIG_SEL_BIT];
    wire trig_stat_w = ctrl_two_q[TRIG_STAT_BIT];
    wire tris_w = ctrl_two_q[TRIS_BIT];
    wire [4:0] src_w = ctrl_two_q[SRC_LSB +: 5];

    wire pwm_w = (mode_w == MODE_EDGE_PWM) || (mode_w == MODE_CENTER_PWM);
    wire entry_w = mode_w != mode_prev_q;
    // timer advances once per instruction cycle
    wire tick_w = phase_q == LAST_PHASE;

    // one comparison width for both halves of a cascaded pair
    function automatic logic same(input logic [31:0] a, input logic [31:0] b,
                                  input logic wide);
        same = wide ? (a == b) : (a[15:0] == b[15:0]);
    endfunction

    // selected source pulse; self uses own secondary match
    function automatic logic src_hit(input logic [4:0] sel,
                                     input logic [31:0] p, input logic self);
        if (sel == SRC_NONE) begin
            src_hit = 1'b0;
        end else if (sel == SRC_SELF) begin
            src_hit = self;
        end else begin
            src_hit = p[sel];
        end
    endfunction

    // byte lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    wire match_pri_w = same(tmr_q, pri_act_q, cascade_w);
    wire match_sec_w = same(tmr_q, sec_act_q, cascade_w);
    wire hit_w = src_hit(src_w, source_pulse, tick_w && match_sec_w);
    // edge pwm ends its period on the secondary match
    wire period_end_w = (mode_w == MODE_EDGE_PWM) ?
                        (tick_w && match_sec_w) : hit_w;
    // trigger mode holds the timer until the trigger status runs
    wire run_w = !trig_sel_w || trig_stat_w;
    wire sync_w = !trig_sel_w && hit_w;
    wire [31:0] tmr_inc_w = cascade_w ? tmr_q + 32'h1 :
                            {16'h0, tmr_q[15:0] + 16'h1};

    ////////////////////////////////////////////////////////////////////
    // axi write path: address and data taken in either order
    wire aw_hs_w = s_axi_awvalid && s_axi_awready;
    wire w_hs_w = s_axi_wvalid && s_axi_wready;
    wire wr_fire_w = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_one_w = wr_fire_w && awaddr_q == ADDR_CTRL_ONE;
    wire wr_two_w = wr_fire_w && awaddr_q == ADDR_CTRL_TWO;
    wire wr_pri_w = wr_fire_w && awaddr_q == ADDR_PRIMARY;
    wire wr_sec_w = wr_fire_w && awaddr_q == ADDR_SECONDARY;
    wire wr_ok_w = wr_one_w || wr_two_w || wr_pri_w || wr_sec_w;
    wire [31:0] wmerge_one_w = merge({24'h0, ctrl_one_q}, wdata_q, wstrb_q);
    wire [31:0] wmerge_two_w = merge({16'h0, ctrl_two_q}, wdata_q, wstrb_q);

    // capture of address and data beats
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs_w) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire_w) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs_w) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire_w) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // ready drops on a beat and returns after the response
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_hs_w) s_axi_awready <= 1'b0;
            if (w_hs_w) s_axi_wready <= 1'b0;
            if (wr_fire_w) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok_w ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read path, answer one cycle after the address
    logic [31:0] rd_mux_w;
    logic rd_ok_w;
    always_comb begin
        rd_ok_w = 1'b1;
        if (s_axi_araddr == ADDR_CTRL_ONE) begin
            rd_mux_w = {24'h0, ctrl_one_q};
        end else if (s_axi_araddr == ADDR_CTRL_TWO) begin
            rd_mux_w = {16'h0, ctrl_two_q};
        end else if (s_axi_araddr == ADDR_PRIMARY) begin
            rd_mux_w = primary_q;
        end else if (s_axi_araddr == ADDR_SECONDARY) begin
            rd_mux_w = secondary_q;
        end else if (s_axi_araddr == ADDR_TIMER) begin
            rd_mux_w = tmr_q;
        end else begin
            rd_mux_w = 32'h0;
            rd_ok_w = 1'b0;
        end
    end

    // read channel handshake
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux_w;
            s_axi_rresp <= rd_ok_w ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers; hardware set wins over software clear
    wire fault_now_w = fault_in && fault_en_w && pwm_w;
    wire trig_set_w = trig_sel_w && hit_w;
    wire trig_hw_clr_w = trig_clear_w && tick_w && match_sec_w;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_one_q <= 8'h00;
            ctrl_two_q <= CTRL_TWO_RESET;
            primary_q <= 32'h0;
            secondary_q <= 32'h0;
        end else begin
            if (wr_one_w) begin
                ctrl_one_q <= wmerge_one_w[7:0] & CTRL_ONE_MASK;
                // fault flag is cleared by writing a one
                ctrl_one_q[FAULT_FLAG_BIT] <= fault_flag_w &&
                                              !wmerge_one_w[FAULT_FLAG_BIT];
            end
            if (fault_now_w) ctrl_one_q[FAULT_FLAG_BIT] <= 1'b1;
            if (wr_two_w) ctrl_two_q <= wmerge_two_w[15:0] & CTRL_TWO_MASK;
            if (trig_hw_clr_w) ctrl_two_q[TRIG_STAT_BIT] <= 1'b0;
            if (trig_set_w) ctrl_two_q[TRIG_STAT_BIT] <= 1'b1;
            if (wr_pri_w) primary_q <= merge(primary_q, wdata_q, wstrb_q);
            if (wr_sec_w) secondary_q <= merge(secondary_q, wdata_q, wstrb_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // time base: quarter phase and channel timer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 2'h0;
            tmr_q <= 32'h0;
        end else begin
            phase_q <= tick_w ? 2'h0 : phase_q + 2'h1;
            if (mode_w == MODE_OFF || !run_w) begin
                tmr_q <= 32'h0;
            end else if (tick_w && mode_w == MODE_EDGE_PWM && match_sec_w) begin
                tmr_q <= 32'h0;
            end else if (sync_w) begin
                tmr_q <= 32'h0;
            end else if (tick_w) begin
                tmr_q <= tmr_inc_w;
            end
        end
    end

    // active compare values and delay, buffered to the period in pwm
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pri_act_q <= 32'h0;
            sec_act_q <= 32'h0;
            dcb_act_q <= 2'h0;
        end else if (!pwm_w || entry_w || period_end_w) begin
            pri_act_q <= primary_q;
            sec_act_q <= secondary_q;
            dcb_act_q <= dcb_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare level per mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            raw_q <= 1'b0;
            shot_q <= SHOT_ARMED;
            mode_prev_q <= MODE_OFF;
        end else begin
            mode_prev_q <= mode_w;
            if (entry_w) begin
                raw_q <= (mode_w == MODE_SET_LOW);
                shot_q <= SHOT_ARMED;
            end else if (tick_w && run_w) begin
                case (mode_w)
                    MODE_SET_HIGH: if (match_pri_w) raw_q <= 1'b1;
                    MODE_SET_LOW: if (match_pri_w) raw_q <= 1'b0;
                    MODE_TOGGLE: if (match_pri_w) raw_q <= !raw_q;
                    MODE_ONE_PULSE: begin
                        if (shot_q == SHOT_ARMED && match_pri_w) begin
                            raw_q <= 1'b1;
                            shot_q <= SHOT_HIGH;
                        end else if (shot_q == SHOT_HIGH && match_sec_w) begin
                            raw_q <= 1'b0;
                            shot_q <= SHOT_DONE;
                        end
                    end
                    MODE_PULSES: begin
                        if (match_pri_w) raw_q <= 1'b1;
                        else if (match_sec_w) raw_q <= 1'b0;
                    end
                    MODE_EDGE_PWM: begin
                        // high at period start, low on the duty match
                        if (match_sec_w) raw_q <= pri_act_q != 32'h0;
                        else if (match_pri_w) raw_q <= 1'b0;
                    end
                    MODE_CENTER_PWM: begin
                        if (match_pri_w) raw_q <= 1'b1;
                        else if (match_sec_w) raw_q <= 1'b0;
                    end
                    default: raw_q <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sub-cycle delay: raw falls wait until the selected quarter;
    // inversion happens after, so the delay lands on the pin's rising edge
    wire no_delay_w = mode_w == MODE_SET_HIGH;
    wire fall_ok_w = no_delay_w || phase_q >= dcb_act_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_raw_q <= 1'b0;
        end else if (raw_q) begin
            pin_raw_q <= 1'b1;
        end else if (fall_ok_w) begin
            pin_raw_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fault state: exit needs source gone plus flag clear or new period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fault_act_q <= 1'b0;
        end else if (fault_now_w) begin
            fault_act_q <= 1'b1;
        end else if (!pwm_w) begin
            fault_act_q <= 1'b0;
        end else if (fault_hold_w ? !fault_flag_w : period_end_w) begin
            fault_act_q <= 1'b0;
        end
    end

    // pin drivers, straight from flip-flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            compare_output_pin <= 1'b0;
            compare_output_oe_n <= 1'b1;
        end else begin
            compare_output_pin <= fault_act_q ? fault_lvl_w
                                              : pin_raw_q ^ invert_w;
            compare_output_oe_n <= tris_w &&
                                   !(fault_act_q && fault_dir_w);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    mode_off_idle_a: assert property (
        (mode_w == MODE_OFF && !entry_w) |=> !raw_q && tmr_q == 32'h0)
        else $error("disabled channel shows compare activity");
    fault_level_a: assert property (
        fault_act_q |=> compare_output_pin == $past(fault_lvl_w))
        else $error("fault level not driven");
    fault_direction_a: assert property (
        (fault_act_q && fault_dir_w) |=> !compare_output_oe_n)
        else $error("fault did not force output direction");
    tristate_pin_a: assert property (
        (tris_w && !fault_act_q) |=> compare_output_oe_n)
        else $error("pin not released when tristated");
    trigger_hold_a: assert property (
        (trig_sel_w && !trig_stat_w) |=> tmr_q == 32'h0)
        else $error("timer runs before trigger");
    trigger_set_a: assert property (
        trig_set_w |=> trig_stat_w)
        else $error("trigger status not set");
    edge_period_a: assert property (
        (mode_w == MODE_EDGE_PWM && !entry_w && tick_w && match_sec_w
         && run_w) |=> tmr_q == 32'h0 ##1 (tmr_q == 32'h0)[*2])
        else $error("edge pwm period did not restart");
    toggle_match_a: assert property (
        (mode_w == MODE_TOGGLE && !entry_w && tick_w && run_w && match_pri_w)
        |=> raw_q != $past(raw_q))
        else $error("toggle mode missed a match");
    falling_delay_a: assert property (
        ($fell(raw_q) && phase_q == 2'h0 && dcb_act_q == 2'h2
         && !no_delay_w) |-> pin_raw_q[*3] ##1 !pin_raw_q)
        else $error("falling edge delay wrong");
    set_high_init_a: assert property (
        (entry_w && mode_w == MODE_SET_HIGH) |=> !raw_q)
        else $error("mode 001 did not start low");

    edge_pwm_c: cover property (mode_w == MODE_EDGE_PWM && $rose(raw_q));
    fault_c: cover property ($rose(fault_act_q));
    one_pulse_c: cover property (shot_q == SHOT_HIGH ##[1:300]
                                 shot_q == SHOT_DONE);
endmodule

// [test/pin_load_model.sv]
// external load on the compare pin, with a weak pull-down
`timescale 1ns/10ps
module pin_load_model (
    input wire logic pin,
    input wire logic oe_n,
    output logic level
);
    // a released pin is pulled low, never left at the last driven value
    assign level = oe_n ? 1'b0 : pin;
endmodule

// [test/output_compare_pwm_channel_tb.sv]
// self-checking bench for the output compare pwm channel
`timescale 1ns/10ps
module output_compare_pwm_channel_tb;
    import oc_chan_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, fault_in = 1'b0;
    logic [31:0] wdata = 32'h0, source_pulse = 32'h0, rd;
    logic [3:0] wstrb = 4'h0;
    wire logic awready, wready, bvalid, arready, rvalid, pin, oe_n, pad;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int miscompares = 0;
    int check_count = 0;
    ////////////////////////////////////////////////////////////////////////
    output_compare_pwm_channel output_compare_pwm_channel_inst (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .source_pulse(source_pulse), .fault_in(fault_in),
        .compare_output_pin(pin), .compare_output_oe_n(oe_n));
    pin_load_model pin_load_model_inst (.pin(pin), .oe_n(oe_n), .level(pad));
    ////////////////////////////////////////////////////////////////////////
    // 125 mhz system clock
    initial forever #4 clk_sys = ~clk_sys;
    // compare helpers, case equality so unknowns never match
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t bit %b expected %b", $time, g, e);
        end
    endtask
    // axi write: both beats offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 64);
        cmp_bit(bvalid, 1'b1);
        cmp_word(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask
    // axi read: address held until taken, data caught at the rvalid edge
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
                          output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 64);
        d = rdata;
        cmp_bit(rvalid, 1'b1);
        cmp_word(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask
    // channel off first, so the final mode write re-initialises every mode except mode 000
    task automatic setup(input logic [7:0] c1, input logic [31:0] pr,
                         input logic [31:0] sc, input logic [15:0] c2);
        axi_wr(ADDR_CTRL_ONE, 32'h0, RESP_OKAY);
        axi_wr(ADDR_PRIMARY, pr, RESP_OKAY);
        axi_wr(ADDR_SECONDARY, sc, RESP_OKAY);
        axi_wr(ADDR_CTRL_TWO, {16'h0, c2}, RESP_OKAY);
        axi_wr(ADDR_CTRL_ONE, {24'h0, c1}, RESP_OKAY);
    endtask
    // high time of the loaded pin over a window of n cycles
    task automatic high_count(input int n, input logic [31:0] e);
        logic [31:0] c;
        c = 32'h0;
        repeat (n) begin
            @(posedge clk_sys);
            if (pad === 1'b1) c++;
        end
        cmp_word(c, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset value, unmapped place and read-only timer
    task automatic t_regs;
        axi_rd(ADDR_CTRL_TWO, RESP_OKAY, rd);
        cmp_word(rd, 32'(CTRL_TWO_RESET));
        axi_wr(8'h20, 32'hffff_ffff, RESP_DECERR);
        axi_rd(8'h20, RESP_DECERR, rd);
        cmp_word(rd, 32'h0);
        // the timer is not a write target, so the write is refused
        axi_wr(ADDR_TIMER, 32'h1234, RESP_DECERR);
        axi_rd(ADDR_TIMER, RESP_OKAY, rd);
        cmp_word(rd, 32'h0);
    endtask
    // compare modes 0 to 7, pin sampled before, between, after matches
    task automatic t_modes;
        logic [2:0] ex [8];
        ex = '{3'b000, 3'b011, 3'b100, 3'b011, 3'b010, 3'b010,
               3'b001, 3'b010};
        for (int m = 0; m < 8; m++) begin
            setup(8'(m), 32'd20, 32'd40, CTRL_TWO_RESET);
            repeat (6) @(posedge clk_sys);
            cmp_bit(pad, ex[m][2]);
            repeat (114) @(posedge clk_sys);
            cmp_bit(pad, ex[m][1]);
            repeat (80) @(posedge clk_sys);
            cmp_bit(pad, ex[m][0]);
        end
    endtask
    // edge pwm, period six ticks, with inversion and edge delay rows
    task automatic t_pwm;
        logic inv [5];
        logic [1:0] dcb [5];
        logic [31:0] ex [5];
        inv = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        dcb = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h3};
        // match acts on the tick that ends a count: high for 3 of 6 ticks
        ex = '{32'd24, 32'd28, 32'd24, 32'd20, 32'd30};
        for (int i = 0; i < 5; i++) begin
            setup({5'h0, MODE_EDGE_PWM}, 32'd2, 32'd5,
                  CTRL_TWO_RESET | {3'h0, inv[i], 1'b0, dcb[i], 9'h0});
            repeat (48) @(posedge clk_sys);
            high_count(48, ex[i]);
        end
    endtask
    // fault on a tristated pwm pin, left by period end or by software
    task automatic t_fault(input logic hold);
        setup(8'h86, 32'd2, 32'd5, CTRL_TWO_RESET | {hold, 15'h6020});
        repeat (40) @(posedge clk_sys);
        cmp_bit(oe_n, 1'b1);
        fault_in <= 1'b1;
        repeat (20) @(posedge clk_sys);
        cmp_bit(oe_n, 1'b0);
        high_count(48, 32'd48);
        axi_rd(ADDR_CTRL_ONE, RESP_OKAY, rd);
        cmp_word(rd & 32'h10, 32'h10);
        fault_in <= 1'b0;
        repeat (40) @(posedge clk_sys);
        high_count(48, hold ? 32'd48 : 32'd0);
        if (hold) begin
            // writing one to the flag lets the held fault go
            axi_wr(ADDR_CTRL_ONE, 32'h96, RESP_OKAY);
            repeat (40) @(posedge clk_sys);
            high_count(48, 32'd0);
        end
    endtask
    // toggle channel held until a capture source triggers it;
    // upper primary half ignored while not cascaded
    task automatic t_trig;
        setup(8'h0b, 32'h0001_0002, 32'd6, 16'h0094);
        axi_rd(ADDR_TIMER, RESP_OKAY, rd);
        cmp_word(rd, 32'h0);
        source_pulse <= 32'h0010_0000;
        @(posedge clk_sys);
        source_pulse <= 32'h0;
        repeat (8) @(posedge clk_sys);
        axi_rd(ADDR_CTRL_TWO, RESP_OKAY, rd);
        cmp_word(rd & 32'h40, 32'h40);
        repeat (40) @(posedge clk_sys);
        axi_rd(ADDR_CTRL_TWO, RESP_OKAY, rd);
        cmp_word(rd & 32'h40, 32'h0);
        cmp_bit(pad, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence after two cycles of reset
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs;
        t_modes;
        t_pwm;
        t_fault(1'b0);
        t_fault(1'b1);
        t_trig;
        test_done;
    end
    // watchdog, well past the expected few thousand cycles
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
endmodule
